// ---- hdl/spe_pkg.sv ----
// Purpose: Shared constants for the serial EEPROM protect and access core
// Assumes: Mode 0 link, 40 MHz core clock
// Notes:   Opcodes are compared after masking bit 3

package spe_pkg;
	localparam logic [7:0] OP_MASK     = 8'hf7;
	localparam logic [7:0] OP_SET_WL   = 8'h06;
	localparam logic [7:0] OP_CLR_WL   = 8'h04;
	localparam logic [7:0] OP_STAT_RD  = 8'h05;
	localparam logic [7:0] OP_STAT_WR  = 8'h01;
	localparam logic [7:0] OP_ARR_RD   = 8'h03;
	localparam logic [7:0] OP_ARR_WR   = 8'h02;
	localparam int         ST_BUSY     = 0;
	localparam int         ST_WEL      = 1;
	localparam int         ST_PLO      = 2;
	localparam int         ST_PHI      = 3;
	localparam int         ST_ARM      = 7;
	localparam logic [7:0] ST_BUSY_VAL = 8'hff;
	localparam int         PAGE_BYTES  = 32;
	localparam int         PAGE_BITS   = 5;
	localparam logic [2:0] NB_ADDR_LO  = 3'h2;
	localparam logic [2:0] NB_DATA     = 3'h3;
	localparam logic [1:0] BP_RESET    = 2'h0;
	localparam logic       ARM_RESET   = 1'b0;
	localparam int         CNT_W       = 24;
	localparam int         CORE_CLK_NS = 25;
	localparam int         PROGRAM_CYCLE_TIME_MS = 5;
	localparam int         PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_MS * 1000000 / CORE_CLK_NS;
	typedef enum logic [1:0] {SPE_IDLE, SPE_COPY, SPE_WAIT} spe_phase_e;
endpackage

// ---- hdl/spe_link.sv ----
// Purpose: Link-side shifter on the serial clock
// Assumes: Mode 0, clock idle low, select high between frames
// Notes:   Captured frame fields stay stable after deselect for the core
`timescale 1ns/100ps
`default_nettype none
module spe_link
	import spe_pkg::*;
(
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_b,
	input  wire logic        spi_si,
	output logic             spi_so,
	output logic             spi_so_oe,
	input  wire logic [7:0]  status_byte,
	input  wire logic [7:0]  rd_data,
	output logic      [15:0] rd_addr,
	output logic      [7:0]  lk_op,
	output logic      [2:0]  lk_bytes,
	output logic             lk_bit_zero,
	output logic      [7:0]  lk_wsr,
	output logic      [31:0] lk_vmask,
	input  wire logic [4:0]  pg_idx,
	output logic      [7:0]  pg_data
);
	typedef struct packed {
		logic [2:0]  bitcnt;
		logic [7:0]  shreg;
		logic [2:0]  nbyte;
		logic [7:0]  op;
		logic [15:0] addr;
		logic [7:0]  wsr;
		logic [31:0] vmask;
		logic [7:0]  st1;
		logic [7:0]  st2;
	} spe_link_s;
	typedef struct packed {
		logic       drv;
		logic [7:0] sh;
	} spe_tx_s;

	spe_link_s  q_ff, b, nxt_q;
	spe_tx_s    tx_ff, nxt_tx;
	logic       fresh_ff;
	logic [7:0] rx;
	logic [7:0] opc;
	logic       pg_we;
	logic [7:0] page_mem [PAGE_BYTES];

	// Marks the first edge of a frame; select high is the only frame reset
	always_ff @(posedge spi_sck or posedge spi_cs_b) begin
		if (spi_cs_b) begin
			fresh_ff <= 1'b1;
		end else begin
			fresh_ff <= 1'b0;
		end
	end

	always_comb begin
		b = q_ff;
		if (fresh_ff) begin
			b.bitcnt = '0;
			b.nbyte  = '0;
			b.vmask  = '0;
		end
		rx = {b.shreg[6:0], spi_si};
		opc = b.op & OP_MASK;
		pg_we = 1'b0;
		nxt_q = b;
		nxt_q.shreg = rx;
		nxt_q.bitcnt = b.bitcnt + 3'h1;
		nxt_q.st1 = status_byte;
		nxt_q.st2 = q_ff.st1;
		if (b.bitcnt == 3'h7) begin
			if (b.nbyte != 3'h7) begin
				nxt_q.nbyte = b.nbyte + 3'h1;
			end
			if (b.nbyte == 3'h0) begin
				nxt_q.op = rx;
			end else if (b.nbyte == 3'h1) begin
				nxt_q.addr[15:8] = rx;
				nxt_q.wsr = rx;
			end else if (b.nbyte == NB_ADDR_LO) begin
				nxt_q.addr[7:0] = rx;
			end else if (opc == OP_ARR_WR && !q_ff.st2[ST_BUSY]) begin
				// Busy gate keeps the page held for the core intact
				pg_we = 1'b1;
				nxt_q.vmask[b.addr[PAGE_BITS-1:0]] = 1'b1;
				nxt_q.addr[PAGE_BITS-1:0] = b.addr[PAGE_BITS-1:0] + 5'h1;
			end else if (opc == OP_ARR_RD) begin
				nxt_q.addr = b.addr + 16'h1;
			end
		end
	end

	always_ff @(posedge spi_sck) begin
		q_ff <= nxt_q;
	end

	always_ff @(posedge spi_sck) begin
		if (pg_we) begin
			page_mem[b.addr[PAGE_BITS-1:0]] <= rx;
		end
	end

	// Output shifts on the falling edge; SI is not looked at here
	always_comb begin
		nxt_tx = tx_ff;
		nxt_tx.sh = {tx_ff.sh[6:0], 1'b0};
		if (q_ff.bitcnt == 3'h0) begin
			nxt_tx.drv = 1'b0;
			if ((q_ff.op & OP_MASK) == OP_STAT_RD && q_ff.nbyte != 3'h0) begin
				nxt_tx.drv = 1'b1;
				nxt_tx.sh = q_ff.st2;
			end else if ((q_ff.op & OP_MASK) == OP_ARR_RD && q_ff.nbyte >= NB_DATA
			             && !q_ff.st2[ST_BUSY]) begin
				nxt_tx.drv = 1'b1;
				nxt_tx.sh = rd_data;
			end
		end
	end

	always_ff @(negedge spi_sck or posedge spi_cs_b) begin
		if (spi_cs_b) begin
			tx_ff <= '0;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	assign spi_so      = tx_ff.sh[7];
	assign spi_so_oe   = tx_ff.drv;
	assign rd_addr     = q_ff.addr;
	assign lk_op       = q_ff.op & OP_MASK;
	assign lk_bytes    = q_ff.nbyte;
	assign lk_bit_zero = (q_ff.bitcnt == 3'h0);
	assign lk_wsr      = q_ff.wsr;
	assign lk_vmask    = q_ff.vmask;
	assign pg_data     = page_mem[pg_idx];
endmodule // spe_link
`default_nettype wire

// ---- hdl/spe_eeprom_core.sv ----
// Purpose: Command, protection and programming core of a serial EEPROM
// Assumes: Select stays high at least 200 ns between frames
// Notes:   Array and status read by the link as quasi-static data
`timescale 1ns/100ps
`default_nettype none
module spe_eeprom_core
	import spe_pkg::*;
#(
	parameter int ADDR_BITS     = 13,
	parameter int PROG_CYCLES_P = PROGRAM_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic spi_sck,
	input  wire logic spi_cs_b,
	input  wire logic spi_si,
	output logic      spi_so,
	output logic      spi_so_oe,
	input  wire logic wp_b
);
	typedef struct packed {
		logic             cs1;
		logic             cs2;
		logic             cs3;
		logic             cs_q;
		logic             wp1;
		logic             wp2;
		logic             wp3;
		logic             wp_q;
		spe_phase_e       phase;
		logic [CNT_W-1:0] cnt;
		logic [5:0]       idx;
		logic             wel;
		logic [1:0]       bp;
		logic             arm;
		logic             busy_fr;
		logic             kind_st;
		logic [7:0]       new_st;
		logic [15:0]      base;
		logic [31:0]      vmask;
	} spe_core_s;

	spe_core_s            q_ff, nxt_q;
	logic                 busy;
	logic                 hwprot;
	logic                 cs_rise;
	logic                 cs_fall;
	logic [7:0]           status_byte;
	logic [15:0]          rd_addr;
	logic [7:0]           rd_data;
	logic [7:0]           lk_op;
	logic [2:0]           lk_bytes;
	logic                 lk_bit_zero;
	logic [7:0]           lk_wsr;
	logic [31:0]          lk_vmask;
	logic [7:0]           pg_data;
	logic                 mem_we;
	logic [ADDR_BITS-1:0] mem_wa;
	logic [7:0]           mem_mem [2**ADDR_BITS];

	// Level 1 is the top quarter, level 2 the top half, level 3 all
	function automatic logic prot_hit(input logic [1:0] lvl, input logic [ADDR_BITS-1:0] a);
		logic hit;
		hit = 1'b0;
		unique case (lvl)
			2'h0: hit = 1'b0;
			2'h1: hit = &a[ADDR_BITS-1:ADDR_BITS-2];
			2'h2: hit = a[ADDR_BITS-1];
			2'h3: hit = 1'b1;
		endcase
		return hit;
	endfunction

	spe_link u_link (
		.spi_sck     (spi_sck),
		.spi_cs_b    (spi_cs_b),
		.spi_si      (spi_si),
		.spi_so      (spi_so),
		.spi_so_oe   (spi_so_oe),
		.status_byte (status_byte),
		.rd_data     (rd_data),
		.rd_addr     (rd_addr),
		.lk_op       (lk_op),
		.lk_bytes    (lk_bytes),
		.lk_bit_zero (lk_bit_zero),
		.lk_wsr      (lk_wsr),
		.lk_vmask    (lk_vmask),
		.pg_idx      (q_ff.idx[PAGE_BITS-1:0]),
		.pg_data     (pg_data)
	);

	assign busy    = (q_ff.phase != SPE_IDLE);
	assign hwprot  = !q_ff.wp_q && q_ff.arm;
	// A change counts once the second and third stages agree
	assign cs_rise = (q_ff.cs2 == q_ff.cs3) && q_ff.cs3 && !q_ff.cs_q;
	assign cs_fall = (q_ff.cs2 == q_ff.cs3) && !q_ff.cs3 && q_ff.cs_q;

	always_comb begin
		status_byte = 8'h00;
		if (busy) begin
			status_byte = ST_BUSY_VAL;
		end else begin
			status_byte[ST_ARM] = q_ff.arm;
			status_byte[ST_PHI] = q_ff.bp[1];
			status_byte[ST_PLO] = q_ff.bp[0];
			status_byte[ST_WEL] = q_ff.wel;
			status_byte[ST_BUSY] = 1'b0;
		end
	end

	// Upper address bits are simply dropped
	assign rd_data = mem_mem[rd_addr[ADDR_BITS-1:0]];

	always_comb begin
		nxt_q = q_ff;
		nxt_q.cs1 = spi_cs_b;
		nxt_q.cs2 = q_ff.cs1;
		nxt_q.cs3 = q_ff.cs2;
		nxt_q.wp1 = wp_b;
		nxt_q.wp2 = q_ff.wp1;
		nxt_q.wp3 = q_ff.wp2;
		if (q_ff.cs2 == q_ff.cs3) begin
			nxt_q.cs_q = q_ff.cs3;
		end
		if (q_ff.wp2 == q_ff.wp3) begin
			nxt_q.wp_q = q_ff.wp3;
		end
		if (cs_fall) begin
			nxt_q.busy_fr = busy;
		end
		mem_we = 1'b0;
		mem_wa = {q_ff.base[ADDR_BITS-1:PAGE_BITS], q_ff.idx[PAGE_BITS-1:0]};
		unique case (q_ff.phase)
			SPE_IDLE: begin
				// Frames opened while busy are dropped whole
				if (cs_rise && !q_ff.busy_fr) begin
					if (lk_op == OP_SET_WL && lk_bytes != 3'h0) begin
						nxt_q.wel = 1'b1;
					end else if (lk_op == OP_CLR_WL && lk_bytes != 3'h0) begin
						nxt_q.wel = 1'b0;
					end else if (lk_op == OP_STAT_WR && q_ff.wel && !hwprot
					             && lk_bytes >= NB_ADDR_LO && lk_bit_zero) begin
						nxt_q.phase = SPE_WAIT;
						nxt_q.cnt = CNT_W'(PROG_CYCLES_P);
						nxt_q.kind_st = 1'b1;
						nxt_q.new_st = lk_wsr;
					end else if (lk_op == OP_ARR_WR && q_ff.wel
					             && lk_bytes > NB_DATA && lk_bit_zero) begin
						nxt_q.phase = SPE_COPY;
						nxt_q.idx = 6'h0;
						nxt_q.kind_st = 1'b0;
						nxt_q.base = rd_addr;
						nxt_q.vmask = lk_vmask;
					end
				end
			end
			SPE_COPY: begin
				if (q_ff.vmask[q_ff.idx[PAGE_BITS-1:0]] && !prot_hit(q_ff.bp, mem_wa)) begin
					mem_we = 1'b1;
				end
				nxt_q.idx = q_ff.idx + 6'h1;
				if (q_ff.idx == 6'(PAGE_BYTES - 1)) begin
					nxt_q.phase = SPE_WAIT;
					nxt_q.cnt = CNT_W'(PROG_CYCLES_P);
				end
			end
			SPE_WAIT: begin
				nxt_q.cnt = q_ff.cnt - CNT_W'(1);
				if (q_ff.cnt <= CNT_W'(1)) begin
					nxt_q.phase = SPE_IDLE;
					nxt_q.wel = 1'b0;
					if (q_ff.kind_st) begin
						nxt_q.arm = q_ff.new_st[ST_ARM];
						nxt_q.bp = {q_ff.new_st[ST_PHI], q_ff.new_st[ST_PLO]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q_ff <= '0;
			q_ff.cs1 <= 1'b1;
			q_ff.cs2 <= 1'b1;
			q_ff.cs3 <= 1'b1;
			q_ff.cs_q <= 1'b1;
			q_ff.wp1 <= 1'b1;
			q_ff.wp2 <= 1'b1;
			q_ff.wp3 <= 1'b1;
			q_ff.wp_q <= 1'b1;
			q_ff.bp <= BP_RESET;
			q_ff.arm <= ARM_RESET;
			q_ff.phase <= SPE_IDLE;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// No reset on the array; its contents model retained cells
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem_mem[mem_wa] <= pg_data;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_frame_end;
		cs_rise && !q_ff.busy_fr && q_ff.phase == SPE_IDLE;
	endsequence

	sequence s_stat_wr_blocked;
		s_frame_end ##0 (lk_op == OP_STAT_WR && hwprot);
	endsequence

	property p_busy_start;
		$rose(busy) |-> $past(q_ff.wel) && $past(cs_rise);
	endproperty

	a_busy_all_ones: assert property (busy |-> status_byte == 8'hff)
		else $error("status not all ones while busy");
	a_idle_bits_low: assert property (!busy |-> status_byte[6:4] == 3'h0 && !status_byte[0])
		else $error("idle status has stray bits");
	a_latch_shown: assert property (!busy |-> status_byte[1] == q_ff.wel)
		else $error("latch bit mismatch");
	a_latch_auto_clear: assert property ($fell(busy) |-> !q_ff.wel)
		else $error("latch not cleared at cycle end");
	a_start_needs_latch: assert property (p_busy_start)
		else $error("program started without latch or deselect");
	a_hw_blocks_status: assert property (s_stat_wr_blocked |=> !busy ##1 !busy)
		else $error("status write taken under pin protection");
	a_arm_held_low: assert property (q_ff.arm && !q_ff.wp_q && !busy |=> q_ff.arm)
		else $error("arm bit dropped while pin low");
	a_no_prot_write: assert property (mem_we |-> q_ff.bp == 2'h0 || (q_ff.bp == 2'h1 && !(&mem_wa[ADDR_BITS-1 -: 2])) || (q_ff.bp == 2'h2 && !mem_wa[ADDR_BITS-1]))
		else $error("write into protected range");
	a_busy_ignores: assert property (cs_rise && q_ff.busy_fr && !busy |=> $stable(q_ff.wel) && !busy)
		else $error("command taken during busy frame");
	a_cycle_min_len: assert property ($rose(busy) |-> busy [*8])
		else $error("programming cycle too short");
endmodule // spe_eeprom_core
`default_nettype wire

// ---- testbench/spe_tb_master.sv ----
// Purpose: Mode 0 link master model for the EEPROM core bench
// Assumes: Serial clock runs only inside frames
// Notes:   Data line toggles when it carries no bit, so a stale level never passes
`timescale 1ns/100ps
`default_nettype none
module spe_tb_master (
	output logic      spi_sck,
	output logic      spi_cs_b,
	output logic      spi_si,
	input  wire logic spi_so,
	input  wire logic spi_so_oe
);
	initial begin
		spi_sck  = 1'b0;
		spi_cs_b = 1'b1;
		spi_si   = 1'b0;
	end

	// Cut above zero sends only that many bits of the last tx byte; any nrd read bytes still follow
	task automatic xfer(input logic [7:0] tx[$], input int nrd, input int cut, output logic [7:0] rx[$]);
		int         nb;
		logic [7:0] b;
		rx = {};
		spi_cs_b = 1'b0;
		#43;
		for (int i = 0; i < tx.size() + nrd; i++) begin
			nb = (cut > 0 && i == tx.size() - 1) ? cut : 8;
			for (int k = 7; k >= 8 - nb; k--) begin
				spi_si = (i < tx.size()) ? tx[i][k] : ~spi_si;
				#80 spi_sck = 1'b1;
				b[k] = spi_so;
				#80 spi_sck = 1'b0;
			end
			if (i >= tx.size()) rx.push_back(b);
		end
		#20 spi_cs_b = 1'b1;
		spi_si = ~spi_si;
		#300;
	endtask
endmodule // spe_tb_master
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the EEPROM command and protect core
// Assumes: Shortened programming time, 8K variant
// Notes:   Array is not reset, so only written bytes are read back
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import spe_pkg::*;
;
	localparam int AB = 13;
	logic       core_clk = 1'b0;
	logic       rst_b    = 1'b0;
	logic       wp_b     = 1'b1;
	logic       spi_sck, spi_cs_b, spi_si, spi_so, spi_so_oe;
	int         n_errors  = 0;
	int         cmp_count = 0;
	int         cyc       = 0;
	logic [31:0] rnd = 32'h53c7bb94;
	logic [7:0] mem [int];
	logic [1:0] m_bp = 2'h0;
	logic       m_arm = 1'b0, m_wel = 1'b0, m_busy = 1'b0;
	logic [7:0] rx[$];

	always #12.5 core_clk = ~core_clk;

	// Busy must outlast a short frame, so frames sent right after a write really meet a busy device
	spe_eeprom_core #(.ADDR_BITS(AB), .PROG_CYCLES_P(400)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
		.spi_sck(spi_sck), .spi_cs_b(spi_cs_b), .spi_si(spi_si), .spi_so(spi_so),
		.spi_so_oe(spi_so_oe), .wp_b(wp_b));
	spe_tb_master u_mst (.spi_sck(spi_sck), .spi_cs_b(spi_cs_b), .spi_si(spi_si), .spi_so(spi_so),
		.spi_so_oe(spi_so_oe));

	function automatic logic [7:0] lfsr_byte();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd[7:0];
	endfunction

	function automatic logic [7:0] m_stat();
		return m_busy ? ST_BUSY_VAL : {m_arm, 3'h0, m_bp, m_wel, 1'b0};
	endfunction

	function automatic bit prot(int a);
		return m_bp != 2'h0 && a >= ((m_bp == 2'h3) ? 0 : (4 - m_bp) * 2 ** (AB - 2));
	endfunction

	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic frame(input logic [7:0] tx[$], input int nrd = 0, input int cut = 0);
		logic [7:0] op;
		logic [7:0] ex[$];
		int         a;
		op = tx[0] & OP_MASK;
		if (m_busy) begin
			if (op == OP_STAT_RD) repeat (nrd) ex.push_back(ST_BUSY_VAL);
		end else if (cut == 0) case (op)
			OP_SET_WL:  m_wel = 1'b1;
			OP_CLR_WL:  m_wel = 1'b0;
			OP_STAT_RD: repeat (nrd) ex.push_back(m_stat());
			OP_ARR_RD: begin
				a = {tx[1], tx[2]};
				repeat (nrd) begin
					a = a % 2 ** AB;
					ex.push_back(mem[a]);
					a++;
				end
			end
			OP_STAT_WR: if (m_wel && !(m_arm && !wp_b)) begin
				{m_arm, m_bp} = {tx[1][7], tx[1][3:2]};
				m_wel = 1'b0;
				m_busy = 1'b1;
			end
			OP_ARR_WR: if (m_wel && tx.size() > 3) begin
				a = {tx[1], tx[2]} % 2 ** AB;
				for (int i = 3; i < tx.size(); i++)
					if (!prot(a - a % 32 + (a + i - 3) % 32)) mem[a - a % 32 + (a + i - 3) % 32] = tx[i];
				m_wel = 1'b0;
				m_busy = 1'b1;
			end
			default: ;
		endcase
		u_mst.xfer(tx, nrd, cut, rx);
		foreach (ex[i]) check("so byte", ex[i], rx[i]);
		check("so_oe after deselect", 8'h00, {7'h0, spi_so_oe});
	endtask

	task automatic page_wr(int adr, int n, int cut = 0);
		logic [7:0] q[$];
		q = '{OP_ARR_WR, adr[15:8], adr[7:0]};
		repeat (n) q.push_back(lfsr_byte());
		frame(q, 0, cut);
	endtask

	// Bounded poll; a stuck busy ends in a mismatch, not a hang
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			u_mst.xfer('{OP_STAT_RD}, 1, 0, rx);
			n++;
		end while (rx[0] === ST_BUSY_VAL && n < 20);
		m_busy = 1'b0;
		check("status after program", m_stat(), rx[0]);
	endtask

	task automatic wr1(int adr, int n);
		frame('{OP_SET_WL});
		page_wr(adr, n);
		wait_ready();
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			report_and_stop();
		end
	end

	initial begin
		int s;
		int b;
		repeat (2) @(posedge core_clk);
		#2 rst_b = 1'b1;
		repeat (8) @(posedge core_clk);
		frame('{OP_STAT_RD}, 2);
		page_wr(16'h0040, 2);
		frame('{OP_STAT_RD}, 1);
		frame('{OP_SET_WL | 8'h08});
		frame('{OP_STAT_RD | 8'h08}, 1);
		frame('{OP_CLR_WL | 8'h08});
		frame('{OP_STAT_RD}, 1);
		$display("test latch done");
		frame('{OP_SET_WL});
		page_wr(16'hffe0, 32);
		frame('{OP_STAT_RD}, 1);
		frame('{OP_SET_WL});
		page_wr(16'h1fe4, 3);
		wait_ready();
		wr1(16'h201e, 34);
		frame('{OP_ARR_RD, 8'hdf, 8'hfc}, 36);
		$display("test page done");
		// Both bytes around each boundary hold known data before any protection
		for (int l = 1; l < 4; l++) begin
			wr1((4 - l) * 2048 - 1, 1);
			wr1((4 - l) * 2048, 1);
		end
		for (int l = 3; l > 0; l--) begin
			s = (4 - l) * 2048;
			b = (s - 1) & 16'h1fff;
			frame('{OP_SET_WL});
			frame('{OP_STAT_WR, {1'b1, 3'h7, l[1:0], 2'h3}});
			wait_ready();
			wr1((s - 32) & 16'h1fff, 32);
			wr1(s, 1);
			frame('{OP_ARR_RD, b[15:8], b[7:0]}, 2);
		end
		$display("test protect done");
		@(posedge core_clk);
		#2 wp_b = 1'b0;
		frame('{OP_SET_WL});
		frame('{OP_STAT_WR, 8'h00});
		frame('{OP_STAT_RD}, 1);
		page_wr(16'h0100, 2);
		wait_ready();
		frame('{OP_ARR_RD, 8'h01, 8'h00}, 2);
		@(posedge core_clk);
		#2 wp_b = 1'b1;
		frame('{OP_SET_WL});
		frame('{OP_STAT_WR, 8'h00});
		wait_ready();
		$display("test pin done");
		frame('{OP_SET_WL});
		page_wr(16'h0100, 2, 3);
		frame('{OP_STAT_RD}, 1);
		frame('{OP_ARR_RD, 8'h01, 8'h00}, 2);
		$display("test abort done");
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
